// file: ctr_regs.svh
// Register offsets, field positions and sizes of the test RAM diagnostic engine
//
// Contract
// (R01) 256K x 32 test memory on the host port; capture runs also write it and playback reads it
// (R02) Memory data feeds host and serializer
// (R03) Each crossbar has two driven test inputs
// (R04) Serializer takes whole word in parallel
// (R05) Lane bits: A trio, B trio, marker, stop
// (R06) One row presented every data clock
// (R07) Stop flag set ends playback
// (R08) Playback ends at full memory count
// (R09) Host configures, enables, starts, then reads lags
// (R10) Diagnostic mode makes its own frame marker
// (R11) Capture sign, magnitude, validity from three switches; code takes two trios, from cap_out0_i and cap_out1_i
// (R12) Pack eight trios per word, write it
// (R13) Captured lane bit 7 stays zero
// (R14) Capture writes start at address zero
// (R15) Capture starts on marker rise, fills memory
// (R16) Host enables capture before start command
// (R17) Error output follows written bit 0
// (R18) Offsets 3 to C select switches 1-10
// (R19) Control parameter offsets decode as listed
// (R20) Space upper half 8010 on strobe zero
// (R21) Diagnostic enable bit 0 low enters mode
// (R22) Capture enable bit 0 low enters mode
// (R23) Any start write launches selected run
// (R24) Config bit 7 routes test, bit 6 picks
// (R25) Start ignored while busy; idle clears address
// (R26) Host memory access held off during run
`ifndef CTR_REGS_SVH
`define CTR_REGS_SVH
`define CTR_SPACE_HI 16'h8010
`define CTR_OFF_XSEL_LO 16'h0003
`define CTR_OFF_XSEL_HI 16'h000C
`define CTR_OFF_APPLY 16'h000D
`define CTR_OFF_SHIFT1 16'h000E
`define CTR_OFF_SHIFT2 16'h000F
`define CTR_OFF_SAMPLE 16'h0010
`define CTR_OFF_ACCUM 16'h0011
`define CTR_OFF_DIAG 16'h0012
`define CTR_OFF_START 16'h0013
`define CTR_OFF_ERROR 16'h0014
`define CTR_OFF_CAPT 16'h0016
`define CTR_CFG_TEST_EN 7
`define CTR_CFG_TEST_SEL 6
`define CTR_TRAM_DEPTH 262144
`define CTR_TRAM_LAST 18'h3FFFF
`define CTR_STOP_MASK 32'h80808080
`define CTR_SHIFT_RST 16'h0000
`endif

// file: ctr_pkg.sv
// Types shared by the test RAM diagnostic engine
package ctr_pkg;
    typedef struct packed {
        logic val;
        logic mag;
        logic sign;
    } ctr_trio_t;
    typedef struct packed {
        logic marker;
        ctr_trio_t b;
        ctr_trio_t a;
    } ctr_sample_t;
    typedef struct packed {
        logic stop;
        ctr_sample_t smp;
    } ctr_lane_t;
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] wdata;
        logic rd;
    } ctr_gbus_t;
    typedef struct packed {
        logic we;
        logic [17:0] addr;
        logic [31:0] wdata;
    } ctr_hreq_t;
    typedef struct packed {
        logic [3:0] sel;
        logic test_en;
        logic test_sel;
        logic [5:0] in_sel;
    } ctr_xcfg_t;
    typedef enum logic [3:0] {
        CTR_IDLE = 4'h1,
        CTR_PLAY = 4'h2,
        CTR_ARM = 4'h4,
        CTR_CAPT = 4'h8
    } ctr_state_t;
endpackage

// file: ctr_serializer.sv
// Splits a test memory word into per-lane crossbar test streams
`timescale 1ns/100ps
module ctr_serializer
    import ctr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [31:0] word_i,
    input wire logic vld_i,
    output ctr_trio_t [3:0] test0_o,
    output ctr_trio_t [3:0] test1_o,
    output logic marker_o
);
    ctr_lane_t [3:0] lane;
    ctr_trio_t [3:0] t0_d;
    ctr_trio_t [3:0] t1_d;
    logic marker_d;

    assign lane = word_i; // R05

    // ******************************
    // Lane split
    // ******************************
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
        assign t0_d[g] = vld_i ? lane[g].smp.a : 3'h0; // R04
        assign t1_d[g] = vld_i ? lane[g].smp.b : 3'h0; // R03
    end

    always_comb
    begin
        marker_d = vld_i & lane[0].smp.marker;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            test0_o <= 12'h000;
            test1_o <= 12'h000;
            marker_o <= 1'h0;
        end
        else
        begin
            test0_o <= t0_d;
            test1_o <= t1_d;
            marker_o <= marker_d;
        end
    end

    a_lane_split: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        vld_i |=> test0_o[2] == $past(word_i[18:16])) else $error("lane 2 A trio wrong"); // R04
endmodule

// file: ctr_capture_packer.sv
// Packs captured crossbar samples four to a word
`timescale 1ns/100ps
module ctr_capture_packer
    import ctr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic en_i,
    input wire ctr_sample_t smp_i,
    output logic [31:0] word_o,
    output logic wvld_o
);
    logic [1:0] idx_q;
    logic [1:0] idx_d;
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic [31:0] word_d;
    logic wvld_d;

    always_comb
    begin
        acc_d = acc_q;
        idx_d = idx_q;
        word_d = word_o;
        wvld_d = 1'h0;
        if (!en_i)
        begin
            idx_d = 2'h0;
        end
        else
        begin
            acc_d[{idx_q, 3'h0} +: 8] = {1'h0, smp_i}; // R13
            idx_d = idx_q + 2'h1;
            if (idx_q == 2'h3)
            begin
                word_d = acc_d; // R12
                wvld_d = 1'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            idx_q <= 2'h0;
            acc_q <= 32'h0;
            word_o <= 32'h0;
            wvld_o <= 1'h0;
        end
        else
        begin
            idx_q <= idx_d;
            acc_q <= acc_d;
            word_o <= word_d;
            wvld_o <= wvld_d;
        end
    end

    a_pack_four: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        wvld_o |-> $past(en_i) && $past(idx_q) == 2'h3 && !word_o[31]) else $error("bad pack"); // R12
endmodule

// file: ctr_diag_top.sv
// Test RAM playback and buffer capture engine with control parameter registers
`timescale 1ns/100ps
`include "ctr_regs.svh"
module ctr_diag_top
    import ctr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire ctr_gbus_t gbus_i,
    input wire logic global_bus_strobe_zero_n_i,
    output logic [15:0] gbus_rdata_o,
    input wire logic host_ram_req_i,
    input wire ctr_hreq_t host_ram_i,
    output logic [31:0] host_ram_rdata_o,
    output logic host_ram_ack_o,
    output logic host_ram_busy_o,
    input wire logic frame_start_marker_i,
    input wire ctr_trio_t cap_out0_i,
    input wire ctr_trio_t cap_out1_i,
    output ctr_trio_t [3:0] test0_o,
    output ctr_trio_t [3:0] test1_o,
    output logic frame_start_marker_o,
    output ctr_xcfg_t xbar_cfg_o,
    output logic xbar_cfg_we_o,
    output logic xbar_apply_o,
    output logic [15:0] shift_sample_one_o,
    output logic [15:0] shift_sample_two_o,
    output logic [15:0] sample_source_o,
    output logic [15:0] accumulate_rate_o,
    output logic diag_mode_o,
    output logic capture_mode_o,
    output logic error_o
);
    function automatic logic reg_hit(input logic [31:0] a, input logic [15:0] off);
        return (a[31:16] == `CTR_SPACE_HI) && (a[15:0] == off);
    endfunction

    // ******************************
    // Bus access detect
    // ******************************
    logic strb_q;
    logic acc;
    logic wr;
    logic rd;
    logic xsel_hit;
    logic start_req;
    logic [15:0] xsel_off;

    always_comb
    begin
        acc = strb_q & ~global_bus_strobe_zero_n_i; // R20
        wr = acc & ~gbus_i.rd;
        rd = acc & gbus_i.rd;
        xsel_off = gbus_i.addr[15:0] - `CTR_OFF_XSEL_LO;
        xsel_hit = (gbus_i.addr[31:16] == `CTR_SPACE_HI) // R18
            && (gbus_i.addr[15:0] >= `CTR_OFF_XSEL_LO)
            && (gbus_i.addr[15:0] <= `CTR_OFF_XSEL_HI);
        start_req = wr & reg_hit(gbus_i.addr, `CTR_OFF_START); // R23
    end

    // ******************************
    // Control parameter registers
    // ******************************
    ctr_state_t state_q;
    ctr_state_t state_d;
    logic [15:0] rdata_d;
    ctr_xcfg_t cfg_d;
    logic cfg_we_d;
    logic apply_d;
    logic [15:0] sh1_d;
    logic [15:0] sh2_d;
    logic [15:0] smp_d;
    logic [15:0] accu_d;
    logic diag_d;
    logic capt_d;
    logic err_d;

    always_comb
    begin
        rdata_d = gbus_rdata_o;
        cfg_d = xbar_cfg_o;
        cfg_we_d = 1'h0;
        apply_d = 1'h0;
        sh1_d = shift_sample_one_o;
        sh2_d = shift_sample_two_o;
        smp_d = sample_source_o;
        accu_d = accumulate_rate_o;
        diag_d = diag_mode_o;
        capt_d = capture_mode_o;
        err_d = error_o;
        if (wr)
        begin
            if (xsel_hit)
            begin
                cfg_d.sel = xsel_off[3:0]; // R18
                cfg_d.test_en = gbus_i.wdata[`CTR_CFG_TEST_EN]; // R24
                cfg_d.test_sel = gbus_i.wdata[`CTR_CFG_TEST_SEL]; // R24
                cfg_d.in_sel = gbus_i.wdata[5:0];
                cfg_we_d = 1'h1;
            end
            apply_d = reg_hit(gbus_i.addr, `CTR_OFF_APPLY); // R19
            if (reg_hit(gbus_i.addr, `CTR_OFF_SHIFT1))
                sh1_d = gbus_i.wdata; // R19
            if (reg_hit(gbus_i.addr, `CTR_OFF_SHIFT2))
                sh2_d = gbus_i.wdata;
            if (reg_hit(gbus_i.addr, `CTR_OFF_SAMPLE))
                smp_d = gbus_i.wdata;
            if (reg_hit(gbus_i.addr, `CTR_OFF_ACCUM))
                accu_d = gbus_i.wdata;
            if (reg_hit(gbus_i.addr, `CTR_OFF_DIAG))
                diag_d = ~gbus_i.wdata[0]; // R21
            if (reg_hit(gbus_i.addr, `CTR_OFF_CAPT))
                capt_d = ~gbus_i.wdata[0]; // R22
            if (reg_hit(gbus_i.addr, `CTR_OFF_ERROR))
                err_d = gbus_i.wdata[0]; // R17
        end
        if (rd)
        begin
            rdata_d = 16'h0000;
            if (reg_hit(gbus_i.addr, `CTR_OFF_SHIFT1))
                rdata_d = shift_sample_one_o;
            if (reg_hit(gbus_i.addr, `CTR_OFF_SHIFT2))
                rdata_d = shift_sample_two_o;
            if (reg_hit(gbus_i.addr, `CTR_OFF_SAMPLE))
                rdata_d = sample_source_o;
            if (reg_hit(gbus_i.addr, `CTR_OFF_ACCUM))
                rdata_d = accumulate_rate_o;
            if (reg_hit(gbus_i.addr, `CTR_OFF_START))
                rdata_d = {14'h0000, (state_q == CTR_ARM) | (state_q == CTR_CAPT),
                    state_q == CTR_PLAY};
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            strb_q <= 1'h1;
            gbus_rdata_o <= 16'h0000;
            xbar_cfg_o <= 12'h000;
            xbar_cfg_we_o <= 1'h0;
            xbar_apply_o <= 1'h0;
            shift_sample_one_o <= `CTR_SHIFT_RST;
            shift_sample_two_o <= `CTR_SHIFT_RST;
            sample_source_o <= `CTR_SHIFT_RST;
            accumulate_rate_o <= `CTR_SHIFT_RST;
            diag_mode_o <= 1'h0;
            capture_mode_o <= 1'h0;
            error_o <= 1'h0;
        end
        else
        begin
            strb_q <= global_bus_strobe_zero_n_i;
            gbus_rdata_o <= rdata_d;
            xbar_cfg_o <= cfg_d;
            xbar_cfg_we_o <= cfg_we_d;
            xbar_apply_o <= apply_d;
            shift_sample_one_o <= sh1_d;
            shift_sample_two_o <= sh2_d;
            sample_source_o <= smp_d;
            accumulate_rate_o <= accu_d;
            diag_mode_o <= diag_d;
            capture_mode_o <= capt_d;
            error_o <= err_d;
        end
    end

    // ******************************
    // Run sequencer
    // ******************************
    logic [17:0] addr_q;
    logic [17:0] addr_d;
    logic pvld_q;
    logic pvld_d;
    logic mkr_q;
    logic mk_rise;
    logic stop_seen;
    logic cap_en;
    logic cap_wvld;
    logic [31:0] cap_word;
    logic [31:0] ram_rd_q;
    logic ack_d;
    logic busy_d;
    logic marker_d;
    logic ser_marker;
    ctr_sample_t cap_smp;

    always_comb
    begin
        mk_rise = frame_start_marker_i & ~mkr_q;
        stop_seen = pvld_q & (|(ram_rd_q & `CTR_STOP_MASK)); // R07
        cap_en = (state_q == CTR_CAPT) | ((state_q == CTR_ARM) & mk_rise); // R15
        cap_smp = {frame_start_marker_i, cap_out1_i, cap_out0_i}; // R11
        state_d = state_q;
        addr_d = addr_q;
        pvld_d = 1'h0;
        unique case (state_q)
            CTR_IDLE:
            begin
                if (start_req && capture_mode_o)
                    state_d = CTR_ARM; // R23
                else if (start_req && diag_mode_o)
                    state_d = CTR_PLAY;
            end
            CTR_PLAY:
            begin
                pvld_d = ~stop_seen; // R06
                addr_d = addr_q + 18'h00001;
                if (stop_seen || addr_q == `CTR_TRAM_LAST) // R08
                begin
                    state_d = CTR_IDLE; // R25
                    addr_d = 18'h00000;
                end
            end
            CTR_ARM:
            begin
                if (mk_rise)
                    state_d = CTR_CAPT; // R15
            end
            CTR_CAPT:
            begin
                if (cap_wvld)
                begin
                    addr_d = addr_q + 18'h00001; // R14
                    if (addr_q == `CTR_TRAM_LAST)
                    begin
                        state_d = CTR_IDLE; // R15
                        addr_d = 18'h00000;
                    end
                end
            end
            default:
            begin
                state_d = CTR_IDLE;
                addr_d = 18'h00000;
            end
        endcase
        busy_d = state_d != CTR_IDLE; // R26
        ack_d = (state_q == CTR_IDLE) & host_ram_req_i; // R26
        marker_d = diag_mode_o ? ser_marker : frame_start_marker_i; // R10
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= CTR_IDLE;
            addr_q <= 18'h00000;
            pvld_q <= 1'h0;
            mkr_q <= 1'h0;
            host_ram_ack_o <= 1'h0;
            host_ram_busy_o <= 1'h0;
            frame_start_marker_o <= 1'h0;
        end
        else
        begin
            state_q <= state_d;
            addr_q <= addr_d;
            pvld_q <= pvld_d;
            mkr_q <= frame_start_marker_i;
            host_ram_ack_o <= ack_d;
            host_ram_busy_o <= busy_d;
            frame_start_marker_o <= marker_d;
        end
    end

    // ******************************
    // Test memory
    // ******************************
    logic [31:0] mem [`CTR_TRAM_DEPTH];
    logic [17:0] ram_addr;
    logic ram_we;
    logic [31:0] ram_wdata;

    always_comb
    begin
        ram_addr = (state_q == CTR_IDLE) ? host_ram_i.addr : addr_q; // R26
        ram_we = ((state_q == CTR_IDLE) & host_ram_req_i & host_ram_i.we)
            | ((state_q == CTR_CAPT) & cap_wvld); // R12
        ram_wdata = (state_q == CTR_IDLE) ? host_ram_i.wdata : cap_word;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (ram_we)
            mem[ram_addr] <= ram_wdata; // R01
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            ram_rd_q <= 32'h0;
        else
            ram_rd_q <= mem[ram_addr]; // R02
    end

    assign host_ram_rdata_o = ram_rd_q;

    ctr_serializer u_ser (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .word_i(ram_rd_q),
        .vld_i(pvld_q & ~stop_seen),
        .test0_o(test0_o),
        .test1_o(test1_o),
        .marker_o(ser_marker)
    );

    ctr_capture_packer u_pack (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .en_i(cap_en),
        .smp_i(cap_smp),
        .word_o(cap_word),
        .wvld_o(cap_wvld)
    );

    // ******************************
    // Checks
    // ******************************
    a_error_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        wr && reg_hit(gbus_i.addr, `CTR_OFF_ERROR) |=> error_o == $past(gbus_i.wdata[0]))
        else $error("error output not updated"); // R17
    a_diag_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        wr && reg_hit(gbus_i.addr, `CTR_OFF_DIAG) |=> diag_mode_o != $past(gbus_i.wdata[0]))
        else $error("diagnostic mode wrong polarity"); // R21
    a_start_ignored: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        start_req && state_q == CTR_PLAY && !stop_seen && addr_q != `CTR_TRAM_LAST
        |=> state_q == CTR_PLAY) else $error("start disturbed a run"); // R25
    a_stop_ends: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        state_q == CTR_PLAY && stop_seen |=> state_q == CTR_IDLE && addr_q == 18'h00000
        ##1 !pvld_q) else $error("stop flag did not end playback"); // R07
    a_play_end: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        state_q == CTR_PLAY && addr_q == `CTR_TRAM_LAST |=> state_q == CTR_IDLE)
        else $error("playback ran past memory end"); // R08
    a_capt_zero: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        state_q == CTR_ARM |-> addr_q == 18'h00000) else $error("capture not at zero"); // R14
    a_capt_rise: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        state_q == CTR_ARM && $rose(frame_start_marker_i) |=> state_q == CTR_CAPT ##3
        cap_wvld && cap_word[6] == 1'h1) else $error("capture missed marker rise"); // R15
    a_host_held: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        state_q != CTR_IDLE |=> !host_ram_ack_o) else $error("host served during run"); // R26
endmodule

// file: ctr_xbar_model.sv
// Far-side model: crossbar capture outputs and backplane frame marker
`timescale 1ns/100ps
module ctr_xbar_model
    import ctr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic run_i,
    output logic marker_o,
    output ctr_trio_t out0_o,
    output ctr_trio_t out1_o
);
    ctr_sample_t smp_log [0:127];
    logic [15:0] cnt;
    logic [15:0] fc;
    int idx;
    initial
    begin
        cnt = 16'h0000;
        fc = 16'h0000;
        idx = 0;
    end
    // Data lines free-run, frame or not: out0 changes every cycle, out1 every eighth cycle
    always @(negedge clk_sys_i)
    begin
        fc <= fc + 16'h0001;
        cnt <= run_i ? cnt + 16'h0001 : 16'h0000;
    end
    assign out0_o = ctr_trio_t'(fc[2:0]);
    assign out1_o = ctr_trio_t'(fc[5:3] ^ 3'h5);
    assign marker_o = run_i && (cnt[4:0] >= 5'h08) && (cnt[4:0] < 5'h0C);
    // Log of what was offered, from the first marker rise on
    always @(posedge clk_sys_i)
    begin
        if (!run_i)
            idx <= 0;
        else if ((marker_o || idx > 0) && idx < 128)
        begin
            smp_log[idx] <= {marker_o, out1_o, out0_o};
            idx <= idx + 1;
        end
    end
endmodule

// file: test_correlator_test_ram_diagnostics.sv
// Self-checking bench of the test RAM diagnostic engine
`timescale 1ns/100ps
`include "ctr_regs.svh"
module test_correlator_test_ram_diagnostics
    import ctr_pkg::*;
;
    logic clk_sys_i;
    logic reset_n_i;
    ctr_gbus_t gbus;
    logic strobe_n;
    logic host_req;
    ctr_hreq_t hreq;
    logic run;
    logic [15:0] gbus_rdata;
    logic [31:0] hram_rdata;
    logic hram_ack;
    logic hram_busy;
    logic marker_in;
    ctr_trio_t cap0;
    ctr_trio_t cap1;
    ctr_trio_t [3:0] test0;
    ctr_trio_t [3:0] test1;
    ctr_xcfg_t xcfg;
    logic xcfg_we;
    logic xapply;
    logic [15:0] shs1, shs2, ssrc, accr;
    logic diag_mode, capt_mode, err_out;
    logic marker_out, we_seen, apply_seen;
    int err_count, check_count, cyc;
    logic [31:0] seed, rd;
    logic [31:0] rows [0:15];
    logic [15:0] vals [0:3];

    ctr_diag_top dut_u
    (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .gbus_i(gbus),
        .global_bus_strobe_zero_n_i(strobe_n),
        .gbus_rdata_o(gbus_rdata),
        .host_ram_req_i(host_req),
        .host_ram_i(hreq),
        .host_ram_rdata_o(hram_rdata),
        .host_ram_ack_o(hram_ack),
        .host_ram_busy_o(hram_busy),
        .frame_start_marker_i(marker_in),
        .cap_out0_i(cap0),
        .cap_out1_i(cap1),
        .test0_o(test0),
        .test1_o(test1),
        .frame_start_marker_o(marker_out),
        .xbar_cfg_o(xcfg),
        .xbar_cfg_we_o(xcfg_we),
        .xbar_apply_o(xapply),
        .shift_sample_one_o(shs1),
        .shift_sample_two_o(shs2),
        .sample_source_o(ssrc),
        .accumulate_rate_o(accr),
        .diag_mode_o(diag_mode),
        .capture_mode_o(capt_mode),
        .error_o(err_out)
    );

    ctr_xbar_model partner_u
    (
        .clk_sys_i(clk_sys_i),
        .run_i(run),
        .marker_o(marker_in),
        .out0_o(cap0),
        .out1_o(cap1)
    );

    always #5 clk_sys_i = ~clk_sys_i;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] t0(input logic [31:0] w);
        return {20'h00000, w[26:24], w[18:16], w[10:8], w[2:0]};
    endfunction
    function automatic logic [31:0] t1(input logic [31:0] w);
        return {20'h00000, w[29:27], w[21:19], w[13:11], w[5:3]};
    endfunction
    function automatic logic [31:0] capw(input int w);
        logic [31:0] v;
        v = 32'h00000000;
        for (int j = 0; j < 4; j++)
            v[8*j +: 7] = partner_u.smp_log[4*w + j];
        return v;
    endfunction
    task stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask
    task gw(input logic r, input logic [15:0] hi, input logic [15:0] off, input logic [15:0] d);
        @(negedge clk_sys_i);
        gbus = {hi, off, d, r};
        strobe_n = 1'h0;
        @(negedge clk_sys_i);
        strobe_n = 1'h1;
        we_seen = xcfg_we;
        apply_seen = xapply;
        @(negedge clk_sys_i);
    endtask
    task hram(input logic we, input logic [17:0] a, input logic [31:0] d);
        int n;
        @(negedge clk_sys_i);
        hreq = {we, a, d};
        host_req = 1'h1;
        @(negedge clk_sys_i);
        host_req = 1'h0;
        n = 0;
        while (hram_ack !== 1'h1 && n < 4)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        chk("host_ack", 32'h1, 32'(hram_ack));
        rd = hram_rdata;
    endtask
    task play(input int k);
        int n;
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_START, seed[15:0]);
        n = 0;
        while (!(32'(test0) === t0(rows[0]) && 32'(test1) === t1(rows[0])) && n < 4)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        for (int r = 0; r < k; r++)
        begin
            strobe_n = (r == 4) ? 1'h0 : 1'h1;
            if (r > 0)
                chk("marker", {31'h0, rows[r - 1][6]}, {31'h0, marker_out});
            chk("row_a", t0(rows[r]), 32'(test0));
            chk("row_b", t1(rows[r]), 32'(test1));
            chk("busy", 32'h1, 32'(hram_busy));
            @(negedge clk_sys_i);
        end
        n = 0;
        while (hram_busy !== 1'h0 && n < 4)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        @(negedge clk_sys_i);
        chk("ended", 32'h0, 32'(hram_busy));
        chk("test_idle", 32'h0, 32'(test0));
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        clk_sys_i = 1'h0;
        reset_n_i = 1'h0;
        gbus = '0;
        strobe_n = 1'h1;
        host_req = 1'h0;
        hreq = '0;
        run = 1'h0;
        err_count = 0;
        check_count = 0;
        cyc = 0;
        seed = 32'hF2F82448;
        repeat (3) @(negedge clk_sys_i);
        reset_n_i = 1'h1;
        chk("error_rst", 32'h0, 32'(err_out));
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_ERROR, 16'h0001);
        chk("error_set", 32'h1, 32'(err_out));
        gw(1'h0, 16'h9010, `CTR_OFF_ERROR, 16'h0000);
        chk("error_other", 32'h1, 32'(err_out));
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_ERROR, 16'hFFFE);
        chk("error_clr", 32'h0, 32'(err_out));
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            vals[i] = seed[15:0] | 16'h0100;
            gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_SHIFT1 + 16'(i), vals[i]);
        end
        for (int i = 0; i < 4; i++)
        begin
            gw(1'h1, `CTR_SPACE_HI, `CTR_OFF_SHIFT1 + 16'(i), 16'h0000);
            chk("value_rd", 32'(vals[i]), 32'(gbus_rdata));
        end
        chk("shift_one", 32'(vals[0]), 32'(shs1));
        chk("shift_two", 32'(vals[1]), 32'(shs2));
        chk("sample", 32'(vals[2]), 32'(ssrc));
        chk("accum", 32'(vals[3]), 32'(accr));
        gw(1'h1, `CTR_SPACE_HI, 16'h0015, 16'h0000);
        chk("unmapped", 32'h0, 32'(gbus_rdata));
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_DIAG, 16'h0000);
        chk("diag_on", 32'h1, 32'(diag_mode));
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_DIAG, 16'h0001);
        chk("diag_off", 32'h0, 32'(diag_mode));
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_CAPT, 16'hFFFE);
        chk("capt_on", 32'h1, 32'(capt_mode));
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_CAPT, 16'h0001);
        chk("capt_off", 32'h0, 32'(capt_mode));
        for (int s = 1; s <= 10; s++)
        begin
            seed = lfsr(seed);
            gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_XSEL_LO + 16'(s - 1), seed[15:0]);
            chk("xcfg_we", 32'h1, 32'(we_seen));
            chk("xcfg_we_end", 32'h0, 32'(xcfg_we));
            chk("xcfg", {20'h00000, 4'(s - 1), seed[7:0]}, 32'(xcfg));
        end
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_APPLY, 16'h0000);
        chk("apply", 32'h1, 32'(apply_seen));
        chk("apply_end", 32'h0, 32'(xapply));
        $display("registers done");
        for (int r = 0; r < 16; r++)
        begin
            seed = lfsr(seed);
            rows[r] = (seed & 32'h7F7F7F7F) | 32'h00000001;
        end
        rows[12] = rows[12] | 32'h80000000;
        for (int r = 0; r < 16; r++)
            hram(1'h1, 18'(r), rows[r]);
        hram(1'h0, 18'h00005, 32'h00000000);
        chk("host_rd", rows[5], rd);
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_DIAG, 16'h0000);
        play(12);
        rows[3] = rows[3] | 32'h00800000;
        hram(1'h1, 18'h00003, rows[3]);
        play(3);
        $display("playback done");
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_DIAG, 16'h0001);
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_CAPT, 16'h0000);
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_START, 16'h0000);
        run = 1'h1;
        hreq = '0;
        host_req = 1'h1;
        repeat (4)
        begin
            @(negedge clk_sys_i);
            chk("held_off", 32'h0, 32'(hram_ack));
        end
        host_req = 1'h0;
        chk("cap_busy", 32'h1, 32'(hram_busy));
        gw(1'h0, `CTR_SPACE_HI, `CTR_OFF_START, 16'h0000);
        repeat (50) @(negedge clk_sys_i);
        reset_n_i = 1'h0;
        run = 1'h0;
        repeat (2) @(negedge clk_sys_i);
        reset_n_i = 1'h1;
        chk("rst_busy", 32'h0, 32'(hram_busy));
        for (int w = 0; w < 8; w++)
        begin
            hram(1'h0, 18'(w), 32'h00000000);
            chk("cap_word", capw(w), rd);
        end
        $display("capture done");
        stop_test();
    end
endmodule
